// ---- design/scr_defines.svh ----
// Constants for the configuration register bank: host ports, keys,
// indexes, reset values, bit positions and access masks.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// ****************************************
// Host port addresses and keys
// ****************************************
`define SCR_ADDR_W         10
`define SCR_INDEX_PORT     10'h3F0
`define SCR_DATA_PORT      10'h3F1
`define SCR_ALT_INDEX_PORT 10'h370
`define SCR_ALT_DATA_PORT  10'h371
`define SCR_ENTER_KEY      8'h55
`define SCR_EXIT_KEY       8'hAA

// ****************************************
// Register indexes
// ****************************************
`define SCR_IDX_IDE_FDC    8'h00
`define SCR_IDX_PARALLEL   8'h01
`define SCR_IDX_SERIAL     8'h02
`define SCR_IDX_PIN_SETUP  8'h03
`define SCR_LOCK_SPAN_TOP  8'h0F

// ****************************************
// Reset values, writable masks, fixed-one masks
// ****************************************
`define SCR_RST_IDE_FDC    8'h28
`define SCR_RST_PARALLEL   8'h9C
`define SCR_RST_SERIAL     8'h88
`define SCR_RST_PIN_SETUP  8'h78
`define SCR_WM_IDE_FDC     8'h8B
`define SCR_WM_PARALLEL    8'h8C
`define SCR_WM_SERIAL      8'h88
`define SCR_WM_PIN_SETUP   8'hFF
`define SCR_ONE_IDE_FDC    8'h20
`define SCR_ONE_PARALLEL   8'h10
`define SCR_ONE_SERIAL     8'h00
`define SCR_ONE_PIN_SETUP  8'h00
`define SCR_READ_BLOCKED   8'h00
`define SCR_SYNC_IDLE_TOP  4'h3

// ****************************************
// Field positions
// ****************************************
`define SCR_PINF_HI        1
`define SCR_PINF_LO        0
`define SCR_PINF_IDE       2'h2
`define SCR_PINF_ALT_IR    2'h3
`define SCR_BIT_FLOPPY_PWR 3
`define SCR_BIT_VALID      7
`define SCR_BIT_PAR_PWR    2
`define SCR_BIT_PAR_MODE   3
`define SCR_BIT_LOCK       7
`define SCR_BIT_SER1_PWR   3
`define SCR_BIT_SER2_PWR   7

`endif

// ---- design/scr_pkg.sv ----
// Types shared by the configuration register bank modules.
// Assumes scr_defines.svh for all numeric constants.
package scr_pkg;

  // Configuration mode sequencing
  typedef enum logic [1:0] {
    SCR_IDLE,
    SCR_KEY_ONE,
    SCR_CONFIG
  } scr_mode_t;

  typedef logic [7:0] scr_byte_t;

endpackage

// ---- design/scr_cfg_if.sv ----
// Carrier between the host-port logic and the register store.
// Assumes one clock domain; the host side drives write strobe and index.
`timescale 1ns/1ps

interface scr_cfg_if;
  logic            wr;        // One-cycle write pulse
  logic [7:0]      index;     // Current config index
  logic [7:0]      wdata;
  logic [7:0]      rdata;     // Registered read of index
  logic [7:0]      regs [4];  // Live register contents

  modport host  (output wr, output index, output wdata, input rdata, input regs);
  modport store (input wr, input index, input wdata, output rdata, output regs);
endinterface // scr_cfg_if

// ---- design/scr_cfg_store.sv ----
// Storage for the four configuration registers with masked writes.
// Assumes writes already qualified by config mode and the access lock.
`timescale 1ns/1ps
`include "scr_defines.svh"

module scr_cfg_store
  import scr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  scr_cfg_if.store  cfg
);

  // ****************************************
  // Helpers
  // ****************************************
  // Reserved bits never take write data; fixed ones are forced back in
  function automatic scr_byte_t merge(input scr_byte_t old_v, input scr_byte_t new_v,
                                      input scr_byte_t wmask, input scr_byte_t ones);
    merge = (old_v & ~wmask) | (new_v & wmask) | ones;
  endfunction

  scr_byte_t ide_fdc;
  scr_byte_t parallel;
  scr_byte_t serial;
  scr_byte_t pin_setup;
  scr_byte_t par_merged;

  assign par_merged = merge(parallel, cfg.wdata, `SCR_WM_PARALLEL, `SCR_ONE_PARALLEL);

  // ****************************************
  // Register storage
  // ****************************************
  // Only rst (power-up / hard reset) restores defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      ide_fdc   <= `SCR_RST_IDE_FDC;
      parallel  <= `SCR_RST_PARALLEL;
      serial    <= `SCR_RST_SERIAL;
      pin_setup <= `SCR_RST_PIN_SETUP;
    end else if (cfg.wr) begin
      if (cfg.index == `SCR_IDX_IDE_FDC) begin
        ide_fdc <= merge(ide_fdc, cfg.wdata, `SCR_WM_IDE_FDC, `SCR_ONE_IDE_FDC);
      end else if (cfg.index == `SCR_IDX_PARALLEL) begin
        parallel <= par_merged;
        // Lock can only fall; a 1 write never re-opens access
        parallel[`SCR_BIT_LOCK] <= parallel[`SCR_BIT_LOCK] & par_merged[`SCR_BIT_LOCK];
      end else if (cfg.index == `SCR_IDX_SERIAL) begin
        serial <= merge(serial, cfg.wdata, `SCR_WM_SERIAL, `SCR_ONE_SERIAL);
      end else if (cfg.index == `SCR_IDX_PIN_SETUP) begin
        pin_setup <= merge(pin_setup, cfg.wdata, `SCR_WM_PIN_SETUP,
                           `SCR_ONE_PIN_SETUP);
      end
    end
  end

  // ****************************************
  // Registered read port
  // ****************************************
  // Unmapped indexes read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg.rdata <= 8'h00;
    end else if (cfg.index == `SCR_IDX_IDE_FDC) begin
      cfg.rdata <= ide_fdc;
    end else if (cfg.index == `SCR_IDX_PARALLEL) begin
      cfg.rdata <= parallel;
    end else if (cfg.index == `SCR_IDX_SERIAL) begin
      cfg.rdata <= serial;
    end else if (cfg.index == `SCR_IDX_PIN_SETUP) begin
      cfg.rdata <= pin_setup;
    end else begin
      cfg.rdata <= 8'h00;
    end
  end

  assign cfg.regs[0] = ide_fdc;
  assign cfg.regs[1] = parallel;
  assign cfg.regs[2] = serial;
  assign cfg.regs[3] = pin_setup;

endmodule // scr_cfg_store

// ---- design/scr_config_regs.sv ----
// Host-facing configuration register bank: index/data port pair,
// configuration mode keys, access lock and decoded control outputs.
// Assumes an ISA-style I/O cycle with address and data stable while
// the strobe is low; all pins but rst are asynchronous to clk.
//
// Notes on behaviour
// - Power-up loads defaults; ordinary reset keeps registers.
// - Data port 3F1H, or 371H alternate.
// - Index 00H reaches register; default 28H.
// - Pin field selects off, IDE, or alt IR.
// - Field 0x enables IDE pin pull-ups.
// - Reserved bits: bit5 one, others zero.
// - Bit 3 powers floppy controller.
// - Bit 7 software valid flag only.
// - Index 01H reaches parallel register; default 9CH.
// - Bit 2 powers parallel port.
// - Bit 3 printer mode, else extended modes.
// - Parallel reserved bits read fixed.
// - Lock bit falls only; blocks register access.
// - Index 02H reaches serial register; default 88H.
// - Bit 3 powers primary serial port.
// - Bit 7 powers secondary serial port.
// - Serial reserved bits read zero.
// - Power-down leaves address decoding alone.
// - Index 03H reaches next register.
// - Index port 3F0H or 370H selects register.
// - AAH to index port exits configuration.
`timescale 1ns/1ps
`include "scr_defines.svh"

module scr_config_regs
  import scr_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   host_reset,
  input  wire logic                   alt_port_select,
  input  wire logic [`SCR_ADDR_W-1:0] isa_addr,
  input  wire logic                   isa_ior_n,
  input  wire logic                   isa_iow_n,
  input  wire logic [7:0]             isa_data_in,
  output      logic [7:0]             isa_data_out,
  output      logic                   isa_data_oe_n,
  output      logic                   config_mode_active,
  output      logic                   ide_if_enable,
  output      logic                   alt_ir_enable,
  output      logic                   ide_pullup_enable,
  output      logic                   floppy_power,
  output      logic                   config_valid_flag,
  output      logic                   parallel_power,
  output      logic                   parallel_printer_mode,
  output      logic                   parallel_ext_modes_en,
  output      logic                   config_access_lock,
  output      logic                   primary_serial_power,
  output      logic                   secondary_serial_power,
  output      logic [7:0]             pin_function_setup
);

  localparam int SW = `SCR_ADDR_W + 12;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] sync3;

  // Reset to pin idle levels: strobes high, ordinary reset and port
  // select low, so no false edge or reset pulse follows release
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= {`SCR_SYNC_IDLE_TOP, {(SW-4){1'b0}}};
      sync2 <= {`SCR_SYNC_IDLE_TOP, {(SW-4){1'b0}}};
      sync3 <= {`SCR_SYNC_IDLE_TOP, {(SW-4){1'b0}}};
    end else begin
      sync1 <= {alt_port_select, host_reset, isa_ior_n, isa_iow_n, isa_addr, isa_data_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  logic                   alt_lvl;
  logic                   hrst_lvl;
  logic                   ior_n_lvl;
  logic                   iow_n_lvl;
  logic [SW-1:0]          agree;
  logic [`SCR_ADDR_W-1:0] addr_s;
  logic [7:0]             data_s;

  assign agree  = ~(sync2 ^ sync3);
  assign addr_s = sync3[`SCR_ADDR_W+7:8];
  assign data_s = sync3[7:0];

  // Levels change only once two stages agree, rejecting one-cycle glitches
  always_ff @(posedge clk) begin
    if (rst) begin
      alt_lvl   <= 1'b0;
      hrst_lvl  <= 1'b0;
      ior_n_lvl <= 1'b1;
      iow_n_lvl <= 1'b1;
    end else begin
      if (agree[SW-1]) alt_lvl   <= sync3[SW-1];
      if (agree[SW-2]) hrst_lvl  <= sync3[SW-2];
      if (agree[SW-3]) ior_n_lvl <= sync3[SW-3];
      if (agree[SW-4]) iow_n_lvl <= sync3[SW-4];
    end
  end

  // ****************************************
  // Strobe events and port decode
  // ****************************************
  logic wr_evt;
  logic rd_evt;
  logic rd_end;
  logic hit_index;
  logic hit_data;

  assign wr_evt    = agree[SW-4] & ~sync3[SW-4] & iow_n_lvl;
  assign rd_evt    = agree[SW-3] & ~sync3[SW-3] & ior_n_lvl;
  assign rd_end    = agree[SW-3] & sync3[SW-3] & ~ior_n_lvl;
  assign hit_index = addr_s == (alt_lvl ? `SCR_ALT_INDEX_PORT : `SCR_INDEX_PORT);
  assign hit_data  = addr_s == (alt_lvl ? `SCR_ALT_DATA_PORT : `SCR_DATA_PORT);

  // ****************************************
  // Configuration mode sequencing
  // ****************************************
  scr_mode_t mode;
  logic      in_cfg;

  assign in_cfg = mode == SCR_CONFIG;

  // Ordinary reset drops config mode but never touches register contents
  always_ff @(posedge clk) begin
    if (rst || hrst_lvl) begin
      mode <= SCR_IDLE;
    end else if (wr_evt && hit_index) begin
      case (mode)
        SCR_IDLE: begin
          mode <= (data_s == `SCR_ENTER_KEY) ? SCR_KEY_ONE : SCR_IDLE;
        end
        SCR_KEY_ONE: begin
          mode <= (data_s == `SCR_ENTER_KEY) ? SCR_CONFIG : SCR_IDLE;
        end
        SCR_CONFIG: begin
          if (data_s == `SCR_EXIT_KEY) mode <= SCR_IDLE;
        end
        default: begin
          mode <= SCR_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Index register and store access
  // ****************************************
  scr_cfg_if cfg ();

  scr_cfg_store u_store (
    .clk (clk),
    .rst (rst),
    .cfg (cfg)
  );

  logic [7:0] config_index_register;
  logic       lock_open;
  logic       idx_lockable;
  logic       access_ok;

  assign lock_open    = cfg.regs[1][`SCR_BIT_LOCK];
  assign idx_lockable = config_index_register <= `SCR_LOCK_SPAN_TOP;
  assign access_ok    = in_cfg && (lock_open || !idx_lockable);

  // Index only loads inside config mode; the exit key is not kept
  always_ff @(posedge clk) begin
    if (rst) begin
      config_index_register <= 8'h00;
    end else if (wr_evt && hit_index && in_cfg && data_s != `SCR_EXIT_KEY) begin
      config_index_register <= data_s;
    end
  end

  assign cfg.index = config_index_register;

  // Write pulse one cycle after the strobe event
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg.wr    <= 1'b0;
      cfg.wdata <= 8'h00;
    end else begin
      cfg.wr    <= wr_evt && hit_data && access_ok;
      cfg.wdata <= data_s;
    end
  end

  // ****************************************
  // Read data drive
  // ****************************************
  // Store read data is already registered, so it is ready at the event
  always_ff @(posedge clk) begin
    if (rst) begin
      isa_data_out  <= 8'h00;
      isa_data_oe_n <= 1'b1;
    end else if (rd_evt && hit_data && in_cfg) begin
      isa_data_out  <= access_ok ? cfg.rdata : `SCR_READ_BLOCKED;
      isa_data_oe_n <= 1'b0;
    end else if (rd_end || hrst_lvl) begin
      isa_data_oe_n <= 1'b1;
    end
  end

  // ****************************************
  // Decoded control outputs
  // ****************************************
  logic [1:0] pin_field;

  assign pin_field = cfg.regs[0][`SCR_PINF_HI:`SCR_PINF_LO];

  // Power bits gate only the units; no base-address decode is touched here
  always_ff @(posedge clk) begin
    if (rst) begin
      config_mode_active     <= 1'b0;
      ide_if_enable          <= 1'b0;
      alt_ir_enable          <= 1'b0;
      ide_pullup_enable      <= 1'b1;
      floppy_power           <= 1'b1;
      config_valid_flag      <= 1'b0;
      parallel_power         <= 1'b1;
      parallel_printer_mode  <= 1'b1;
      parallel_ext_modes_en  <= 1'b0;
      config_access_lock     <= 1'b1;
      primary_serial_power   <= 1'b1;
      secondary_serial_power <= 1'b1;
      pin_function_setup     <= `SCR_RST_PIN_SETUP;
    end else begin
      config_mode_active     <= in_cfg;
      ide_if_enable          <= pin_field == `SCR_PINF_IDE;
      alt_ir_enable          <= pin_field == `SCR_PINF_ALT_IR;
      ide_pullup_enable      <= ~pin_field[1];
      floppy_power           <= cfg.regs[0][`SCR_BIT_FLOPPY_PWR];
      config_valid_flag      <= cfg.regs[0][`SCR_BIT_VALID];
      parallel_power         <= cfg.regs[1][`SCR_BIT_PAR_PWR];
      parallel_printer_mode  <= cfg.regs[1][`SCR_BIT_PAR_MODE];
      parallel_ext_modes_en  <= ~cfg.regs[1][`SCR_BIT_PAR_MODE];
      config_access_lock     <= cfg.regs[1][`SCR_BIT_LOCK];
      primary_serial_power   <= cfg.regs[2][`SCR_BIT_SER1_PWR];
      secondary_serial_power <= cfg.regs[2][`SCR_BIT_SER2_PWR];
      pin_function_setup     <= cfg.regs[3];
    end
  end

endmodule // scr_config_regs

// ---- verification/scr_config_regs_props.sv ----
// Concurrent checks on the configuration bank's top-level pins.
// Assumes a bind to scr_config_regs; one clock, sync active-high rst.
`timescale 1ns/1ps

module scr_config_regs_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       host_reset,
  input wire logic [9:0] isa_addr,
  input wire logic       isa_ior_n,
  input wire logic       isa_iow_n,
  input wire logic       isa_data_oe_n,
  input wire logic       config_mode_active,
  input wire logic       ide_if_enable,
  input wire logic       alt_ir_enable,
  input wire logic       ide_pullup_enable,
  input wire logic       floppy_power,
  input wire logic       parallel_printer_mode,
  input wire logic       parallel_ext_modes_en,
  input wire logic       config_access_lock,
  input wire logic [7:0] pin_function_setup
);
  // ********
  // Pin checks
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Start of a driven read, a quiet write strobe, a held ordinary reset
  sequence s_read_on;
    $fell(isa_data_oe_n);
  endsequence
  sequence s_quiet;
    isa_iow_n [*8];
  endsequence
  sequence s_hrst;
    host_reset [*8];
  endsequence

  // Reset check ignores the default disable so it can see rst itself
  AST_RST_DEFAULTS: assert property (disable iff (1'b0) rst |=>
    config_access_lock && floppy_power && !config_mode_active && pin_function_setup == 8'h78)
    else $error("defaults not loaded by reset");
  AST_PULLUP_DECODE: assert property (ide_pullup_enable == !(ide_if_enable || alt_ir_enable))
    else $error("pull-up enable disagrees with pin field");
  AST_FIELD_EXCL: assert property (!(ide_if_enable && alt_ir_enable))
    else $error("both pin functions enabled");
  AST_EXT_INV: assert property (parallel_ext_modes_en != parallel_printer_mode)
    else $error("printer and extended modes not exclusive");
  AST_LOCK_STICKY: assert property (!config_access_lock |=> !config_access_lock)
    else $error("access lock reopened without reset");
  AST_READ_DRIVE: assert property (s_read_on |->
    config_mode_active && isa_addr[0] && !$past(isa_ior_n, 3))
    else $error("bus driven without a data-port read in config mode");
  AST_READ_RELEASE: assert property ($rose(isa_ior_n) |-> ##[1:6] isa_data_oe_n)
    else $error("bus not released after read strobe");
  AST_QUIET_STABLE: assert property (s_quiet |=> $stable(pin_function_setup)
    && $stable(config_access_lock) && $stable(floppy_power))
    else $error("register output moved with no write");
  AST_HRST_EXIT: assert property (s_hrst |-> !config_mode_active)
    else $error("ordinary reset left config mode on");
endmodule // scr_config_regs_props

bind scr_config_regs scr_config_regs_props chk (.*);

// ---- verification/scr_host_model.sv ----
// Host processor model issuing ISA I/O cycles to the port pair.
// Assumes one caller at a time; hold sets strobe low and high spans.
`timescale 1ns/1ps

module scr_host_model (
  input  wire logic       clk,
  output      logic [9:0] isa_addr,
  output      logic       isa_ior_n,
  output      logic       isa_iow_n,
  output      logic [7:0] isa_data_in,
  input  wire logic [7:0] isa_data_out,
  input  wire logic       isa_data_oe_n
);
  int hold = 6; // Above the 5-clock minimum; raise it for a slow host

  // ********
  // Bus cycles
  // ********
  // Idle strobes high before reset release
  initial begin
    isa_addr = 10'h000;
    isa_ior_n = 1'b1;
    isa_iow_n = 1'b1;
    isa_data_in = 8'h00;
  end

  // One cycle; released lines show the inverse, never a stale value
  task automatic io(input bit wr, input logic [9:0] a, input logic [7:0] d,
                    output logic [7:0] q, output logic drv);
    @(posedge clk);
    #1;
    isa_addr = a;
    isa_data_in = d;
    if (wr) isa_iow_n = 1'b0;
    else isa_ior_n = 1'b0;
    repeat (hold) @(posedge clk);
    q = isa_data_out;
    drv = (isa_data_oe_n === 1'b0);
    #1;
    isa_iow_n = 1'b1;
    isa_ior_n = 1'b1;
    isa_addr = ~a;
    isa_data_in = ~d;
    repeat (hold) @(posedge clk);
  endtask

  task automatic wr_idx(input logic [9:0] base, input logic [7:0] d);
    logic [7:0] q;
    logic       drv;
    io(1'b1, base, d, q, drv);
  endtask

  task automatic enter(input logic [9:0] base);
    wr_idx(base, 8'h55);
    wr_idx(base, 8'h55);
  endtask

  task automatic leave(input logic [9:0] base);
    wr_idx(base, 8'hAA);
  endtask

  task automatic wr_reg(input logic [9:0] base, input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    logic       drv;
    wr_idx(base, idx);
    io(1'b1, base + 10'h001, d, q, drv);
  endtask

  task automatic rd_reg(input logic [9:0] base, input logic [7:0] idx,
                        output logic [7:0] q, output logic drv);
    wr_idx(base, idx);
    io(1'b0, base + 10'h001, 8'h00, q, drv);
  endtask
endmodule // scr_host_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the configuration register bank.
// Assumes scr_host_model runs every ISA cycle; one 50 MHz clock.
`timescale 1ns/1ps

module tb_top;
  import scr_pkg::*;

  typedef struct packed {
    scr_byte_t idx;
    scr_byte_t wd;
    scr_byte_t rd;
  } scr_row_t;

  localparam logic [9:0] PRI = 10'h3F0;
  localparam logic [9:0] ALT = 10'h370;

  logic       clk, rst, host_reset, alt_port_select, isa_ior_n, isa_iow_n, drv;
  logic       isa_data_oe_n, config_mode_active, ide_if_enable, alt_ir_enable;
  logic       ide_pullup_enable, floppy_power, config_valid_flag, parallel_power;
  logic       parallel_printer_mode, parallel_ext_modes_en, config_access_lock;
  logic       primary_serial_power, secondary_serial_power;
  logic [9:0] isa_addr;
  scr_byte_t  isa_data_in, isa_data_out, pin_function_setup, q;
  scr_byte_t  img [4];
  int         bad_count, total_checks;
  wire logic [18:0] outs = {ide_if_enable, alt_ir_enable, ide_pullup_enable, floppy_power,
    config_valid_flag, parallel_power, parallel_printer_mode, parallel_ext_modes_en,
    config_access_lock, primary_serial_power, secondary_serial_power, pin_function_setup};

  // Index, written byte, byte read back
  scr_row_t rows [12] = '{'{8'h00, 8'h00, 8'h20}, '{8'h00, 8'h01, 8'h21},
    '{8'h00, 8'h02, 8'h22}, '{8'h00, 8'hFF, 8'hAB}, '{8'h01, 8'hF3, 8'h90},
    '{8'h01, 8'h84, 8'h94}, '{8'h01, 8'h8C, 8'h9C}, '{8'h02, 8'h77, 8'h00},
    '{8'h02, 8'h08, 8'h08}, '{8'h02, 8'hF7, 8'h80}, '{8'h03, 8'hA5, 8'hA5},
    '{8'h04, 8'h5A, 8'h00}};

  scr_config_regs dut (.*);
  scr_host_model  host (.*);

  // ********
  // Helpers
  // ********
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Decoded pins expected from the register image
  function automatic logic [18:0] exp_outs();
    return {img[0][1:0] == 2'b10, img[0][1:0] == 2'b11, !img[0][1], img[0][3], img[0][7],
            img[1][2], img[1][3], !img[1][3], img[1][7], img[2][3], img[2][7], img[3]};
  endfunction

  task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[FAIL] run expected done seen timeout");
    tally_and_finish();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    rst = 1'b1;
    host_reset = 1'b0;
    alt_port_select = 1'b0;
    img = '{8'h28, 8'h9C, 8'h88, 8'h78};
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    host.wr_reg(PRI, 8'h00, 8'h00);
    host.rd_reg(PRI, 8'h00, q, drv);
    chk("drv_idle", 19'h0, drv);
    host.enter(PRI);
    chk("mode_on", 19'h1, config_mode_active);
    for (int i = 0; i < 4; i++) begin
      host.rd_reg(PRI, 8'(i), q, drv);
      chk("default", {1'b1, img[i]}, {drv, q});
    end
    foreach (rows[i]) begin
      host.wr_reg(PRI, rows[i].idx, rows[i].wd);
      host.rd_reg(PRI, rows[i].idx, q, drv);
      if (rows[i].idx < 8'h04) img[rows[i].idx[1:0]] = rows[i].rd;
      chk("readback", {1'b1, rows[i].rd}, {drv, q});
      chk("outputs", exp_outs(), outs);
    end
    host.leave(PRI);
    host.rd_reg(PRI, 8'h00, q, drv);
    chk("drv_exit", 19'h0, drv);
    host.wr_idx(PRI, 8'h55);
    host.wr_idx(PRI, 8'h01);
    host.wr_idx(PRI, 8'h55);
    chk("mode_broken", 19'h0, config_mode_active);
    host.wr_idx(PRI, 8'h55);
    chk("mode_again", 19'h1, config_mode_active);
    // Ordinary reset drops the mode but keeps every register
    @(posedge clk);
    #1 host_reset = 1'b1;
    repeat (8) @(posedge clk);
    #1 host_reset = 1'b0;
    repeat (6) @(posedge clk);
    chk("mode_hrst", 19'h0, config_mode_active);
    chk("outs_hrst", exp_outs(), outs);
    // Alternate pair with a slow host
    #1 alt_port_select = 1'b1;
    host.hold = 10;
    host.enter(ALT);
    host.wr_reg(ALT, 8'h02, 8'h08);
    img[2] = 8'h08;
    host.rd_reg(ALT, 8'h02, q, drv);
    chk("alt_read", {1'b1, 8'h08}, {drv, q});
    host.io(1'b0, ALT, 8'h00, q, drv);
    chk("idx_read", 19'h0, drv);
    // Lock closes, then holds against writes until rst
    host.wr_reg(ALT, 8'h01, 8'h0C);
    img[1] = 8'h1C;
    host.wr_reg(ALT, 8'h01, 8'h8C);
    host.wr_reg(ALT, 8'h00, 8'h00);
    host.rd_reg(ALT, 8'h00, q, drv);
    chk("locked_read", {1'b1, 8'h00}, {drv, q});
    chk("outs_locked", exp_outs(), outs);
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    img = '{8'h28, 8'h9C, 8'h88, 8'h78};
    @(posedge clk);
    chk("outs_rst", exp_outs(), outs);
    chk("mode_rst", 19'h0, config_mode_active);
    tally_and_finish();
  end
endmodule // tb_top
